// ---- bench/wfm_frame_src.sv ----
`timescale 1ns/10ps
module wfm_frame_src
  import wfm_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         slow,
  input  wire logic [511:0] frame,
  input  wire logic [6:0]   len,
  output wfm_rx_s           rx,
  output logic              busy
);
  logic [6:0] cnt;
  logic       hold;

  // Idle data toggles so that a stale byte can never pass for a fresh one.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx   <= '0;
      busy <= 1'b0;
      cnt  <= 7'h00;
      hold <= 1'b0;
    end else if (busy && slow && !hold) begin
      rx.valid <= 1'b0;
      rx.last  <= 1'b0;
      rx.data  <= ~rx.data;
      hold     <= 1'b1;
    end else if (busy) begin
      rx.valid <= 1'b1;
      rx.data  <= frame[8*cnt +: 8];
      rx.last  <= (cnt == len - 7'h01);
      busy     <= (cnt != len - 7'h01);
      cnt      <= cnt + 7'h01;
      hold     <= 1'b0;
    end else begin
      rx.valid <= 1'b0;
      rx.last  <= 1'b0;
      rx.data  <= ~rx.data;
      busy     <= start;
      cnt      <= 7'h00;
    end
  end
endmodule : wfm_frame_src

// ---- bench/wfm_top_bench.sv ----
`timescale 1ns/10ps
module wfm_top_bench
  import wfm_pkg::*;
;
  logic         clock, rst, psel, penable, pwrite, start, slow;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, irq, er, busy, ce;
  logic [2:0]   wake_event;
  logic [511:0] frame;
  logic [6:0]   len;
  wfm_rx_s      rx;
  int           miscompares, cmp_count;

  wfm_top dut (.CLOCK(clock), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_VALID(rx.valid), .RX_LAST(rx.last),
    .RX_DATA(rx.data), .WAKE_EVENT(wake_event), .IRQ(irq));
  wfm_frame_src src (.clock(clock), .rst(rst), .start(start), .slow(slow), .frame(frame),
    .len(len), .rx(rx), .busy(busy));

  task summarize;
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Starts one edge late so a release and the next setup never meet in one step.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask : apb

  task send(input logic sl, output logic [2:0] ev);
    int n;
    n = 0;
    ev = 3'h0;
    @(posedge clock);
    slow <= sl;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (busy !== 1'b0 && n < 300);
    if (busy !== 1'b0) begin
      miscompares++;
      summarize();
    end
    repeat (4) begin
      @(posedge clock);
      ev = ev | wake_event;
    end
  endtask : send

  function automatic logic [31:0] crc_sel(input logic [511:0] f, input logic [63:0] m);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 64; i++) begin
      for (int k = 0; k < 8; k++) begin
        if (m[i]) c = (c[0] ^ f[8*i+k]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc_sel

  task regs_test;
    logic [3:0] b;
    logic [5:0] i;
    for (b = 4'h5; b <= 4'h7; b++) begin
      apb(1'b1, 8'h38, {28'h0, b});
      for (i = 6'h00; i <= 6'h0a; i = i + 6'h02) begin
        apb(1'b0, {i, 2'b00}, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, {i, 2'b00}, {16'hdead, 4'hc, b, 2'b00, i});
      end
    end
    for (b = 4'h5; b <= 4'h7; b++) begin
      apb(1'b1, 8'h38, {28'h0, b});
      for (i = 6'h00; i <= 6'h0a; i = i + 6'h02) begin
        apb(1'b0, {i, 2'b00}, 32'h0);
        chk(rd, {16'h0, 4'hc, b, 2'b00, i});
      end
    end
  endtask : regs_test

  task window_test;
    apb(1'b1, 8'h38, 32'h9);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h10, 32'hffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h9);
    apb(1'b1, 8'h38, 32'h6);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : window_test

  task match_test;
    logic [31:0] c;
    logic [2:0]  ev;
    int          pos[4];
    pos = '{0, 120, 128, 504};
    for (int i = 0; i < 64; i++) frame[8*i +: 8] = 8'(i * 29 + 5);
    c = crc_sel(frame, 64'h8000_0000_0001_8001);
    apb(1'b1, 8'h00, {16'h0, c[15:0]});
    apb(1'b1, 8'h08, {16'h0, c[31:16]});
    apb(1'b1, 8'h10, 32'h8001);
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b1, 8'h28, 32'h8000);
    apb(1'b1, 8'h48, 32'h4);
    apb(1'b1, 8'h40, 32'h4);
    send(1'b0, ev);
    chk({29'h0, ev}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, 8'h44, 32'h4);
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    frame[15:8] = ~frame[15:8];
    send(1'b1, ev);
    chk({29'h0, ev}, 32'h2);
    foreach (pos[j]) begin
      frame[pos[j]] = ~frame[pos[j]];
      send(1'b0, ev);
      chk({29'h0, ev}, 32'h0);
      frame[pos[j]] = ~frame[pos[j]];
    end
    ce <= 1'b0;
    send(1'b0, ev);
    ce <= 1'b1;
    chk({29'h0, ev}, 32'h0);
    apb(1'b1, 8'h40, 32'h0);
    send(1'b0, ev);
    chk({29'h0, ev}, 32'h0);
  endtask : match_test

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start = 1'b0;
    slow = 1'b0;
    frame = '0;
    len = 7'h40;
    miscompares = 0;
    cmp_count = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    regs_test();
    window_test();
    match_test();
    summarize();
  end
endmodule : wfm_top_bench

// ---- core/wfm_crc_byte.sv ----
`timescale 1ns/10ps
module wfm_crc_byte
  import wfm_pkg::*;
(
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);
  logic [31:0] c [0:8];

  assign c[0] = crc_in;

  // Reflected 802.3 polynomial, least significant data bit first.
  for (genvar b = 0; b < 8; b++) begin : g_bit
    assign c[b+1] = (c[b][0] ^ data[b]) ? ((c[b] >> 1) ^ CRC_POLY) : (c[b] >> 1);
  end

  assign crc_out = c[8];
endmodule : wfm_crc_byte

// ---- core/wfm_matcher.sv ----
`timescale 1ns/10ps
module wfm_matcher
  import wfm_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire wfm_rx_s       rx,
  input  wire logic          sel,
  input  wire logic          en,
  input  wire logic [31:0]   crc_exp,
  output logic               hit
);
  logic [31:0] crc;
  logic [31:0] crc_step;
  logic [31:0] next_crc;

  wfm_crc_byte u_step (
    .crc_in  (crc),
    .data    (rx.data),
    .crc_out (crc_step)
  );

  assign next_crc = (rx.valid & en & sel) ? crc_step : crc; // [R5]
  assign hit = rx.valid & rx.last & en & ce & (~next_crc == crc_exp); // [R10]

  // A disabled pattern keeps its CRC parked at the seed, so a late enable starts from the seed
  // and runs the CRC over only the rest of the frame.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc <= CRC_INIT;
    end else if (ce & rx.valid) begin
      crc <= (rx.last | ~en) ? CRC_INIT : next_crc; // [R9]
    end
  end

  a_skip_unselected: assert property (@(posedge clock) disable iff (rst) // [R5]
    ce & rx.valid & ~rx.last & en & ~sel |=> crc == $past(crc))
    else $error("Unselected byte changed the running CRC.");
endmodule : wfm_matcher

// ---- core/wfm_pkg.sv ----
package wfm_pkg;
  localparam int unsigned NPAT       = 3;
  localparam int unsigned NSLOT      = 6;
  localparam int unsigned MASK_BYTES = 64;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_CRC_LOW  = 6'h00;
  localparam logic [5:0] IDX_CRC_HIGH = 6'h02;
  localparam logic [5:0] IDX_MASK0    = 6'h04;
  localparam logic [5:0] IDX_MASK1    = 6'h06;
  localparam logic [5:0] IDX_MASK2    = 6'h08;
  localparam logic [5:0] IDX_MASK3    = 6'h0a;
  localparam logic [5:0] IDX_BANK_SEL = 6'h0e;
  localparam logic [5:0] IDX_ENABLE   = 6'h10;
  localparam logic [5:0] IDX_STATUS   = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;

  localparam logic [3:0]  BANK_FIRST_PAT = 4'h5;
  localparam logic [3:0]  BANK_LAST_PAT  = 4'h7;
  localparam logic [3:0]  BANK_RESET     = 4'h0;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [2:0]  FLAG_RESET     = 3'h0;
  localparam int unsigned FLAG_LSB       = 1;

  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } wfm_rx_s;

  typedef enum logic {
    APB_WAIT,
    APB_ANSWER
  } wfm_apb_e;
endpackage : wfm_pkg

// ---- core/wfm_top.sv ----
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
// Function
// [R1] Four 16-bit byte masks per pattern at offsets 0x04 to 0x0A cover 64 bytes.
// [R2] Mask bit 0 picks the lowest byte of its group, bit 15 the highest.
// [R3] First mask register bit 0 is the frame's first byte.
// [R4] Expected CRC low half at offset 0x00, high half at 0x02.
// [R5] Ethernet CRC runs only over bytes whose mask bit is set.
// [R6] Patterns 1, 2, 3 live in banks 5, 6, 7 at identical offsets.
// [R7] All mask and CRC registers are read-write and reset to zero.
// [R8] Banks 8 to 15 are empty but bank select at 0xE still works.
// [R9] Each pattern matches only while its enable bit is set.
// [R10] Enabled pattern whose masked CRC equals the stored value flags a wake event.
module wfm_top
  import wfm_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_VALID,
  input  wire logic        RX_LAST,
  input  wire logic [7:0]  RX_DATA,
  output logic      [2:0]  WAKE_EVENT,
  output logic             IRQ
);
  logic [15:0]     store [NPAT][NSLOT];
  logic [3:0]      bank_sel;
  logic [2:0]      pat_en;
  logic [2:0]      status;
  logic [2:0]      irq_mask;
  logic [6:0]      pos;
  wfm_apb_e        apb_state;

  wire logic [5:0] idx;
  wire logic [3:0] pat_off;
  wire logic [1:0] pat;
  wire logic [2:0] slot;
  wire logic       in_pat_bank;
  wire logic       in_win;
  wire logic       hit_store;
  wire logic       hit_bank;
  wire logic       hit_en;
  wire logic       hit_stat;
  wire logic       hit_imask;
  wire logic       mapped;
  wire logic       commit;
  wire logic       wr;
  wire logic [15:0] wdata16;
  wire logic [15:0] store_rd;
  wire logic [31:0] rd_mux;
  wire logic       in_mask_window;
  wire wfm_rx_s    rx;
  wire logic [2:0] hit;
  logic [2:0]      next_status;

  // Bus decode. The bank window is only decoded for the three pattern banks.
  assign idx         = PADDR[7:2];
  assign pat_off     = bank_sel - BANK_FIRST_PAT;
  assign pat         = pat_off[1:0];
  assign slot        = idx[3:1];
  assign in_pat_bank = (bank_sel >= BANK_FIRST_PAT) && (bank_sel <= BANK_LAST_PAT); // [R6]
  assign in_win      = (idx <= IDX_MASK3) && !idx[0]; // [R1] [R4]
  assign hit_store   = in_pat_bank & in_win;
  assign hit_bank    = (idx == IDX_BANK_SEL); // [R8]
  assign hit_en      = (idx == IDX_ENABLE);
  assign hit_stat    = (idx == IDX_STATUS);
  assign hit_imask   = (idx == IDX_IRQ_MASK);
  assign mapped      = hit_store | hit_bank | hit_en | hit_stat | hit_imask;
  assign commit      = PSEL & PENABLE & PREADY & CE;
  assign wr          = commit & PWRITE;
  assign wdata16     = PWDATA[15:0];
  assign store_rd    = hit_store ? store[pat][slot] : REG_RESET;

  assign rd_mux = hit_store ? {16'h0000, store_rd}                         :
                  hit_bank  ? {28'h0000000, bank_sel}                      :
                  hit_en    ? {28'h0000000, pat_en, 1'b0}                  :
                  hit_stat  ? {28'h0000000, status, 1'b0}                  :
                  hit_imask ? {28'h0000000, irq_mask, 1'b0}                :
                              32'h00000000;

  // One wait state: PREADY and PRDATA both come from flops, so the answer is
  // registered in the first access cycle and presented in the second.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      apb_state <= APB_WAIT;
      PREADY    <= 1'b0;
      PRDATA    <= 32'h00000000;
      PSLVERR   <= 1'b0;
    end else if (CE) begin
      case (apb_state)
        APB_WAIT: begin
          if (PSEL & PENABLE) begin
            apb_state <= APB_ANSWER;
            PREADY    <= 1'b1;
            PRDATA    <= PWRITE ? 32'h00000000 : rd_mux;
            PSLVERR   <= ~mapped;
          end
        end
        APB_ANSWER: begin
          apb_state <= APB_WAIT;
          PREADY    <= 1'b0;
          PSLVERR   <= 1'b0;
        end
        default: begin
          apb_state <= APB_WAIT;
          PREADY    <= 1'b0;
        end
      endcase
    end
  end

  // Pattern store. Byte lanes 0 and 1 carry the 16-bit value; upper lanes are ignored.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < NPAT; p++) begin
        for (int s = 0; s < NSLOT; s++) begin
          store[p][s] <= REG_RESET; // [R7]
        end
      end
    end else if (wr & hit_store) begin
      if (PSTRB[0]) begin
        store[pat][slot][7:0] <= wdata16[7:0]; // [R7]
      end
      if (PSTRB[1]) begin
        store[pat][slot][15:8] <= wdata16[15:8];
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      bank_sel <= BANK_RESET;
      pat_en   <= FLAG_RESET;
      irq_mask <= FLAG_RESET;
    end else if (wr & PSTRB[0]) begin
      if (hit_bank) begin
        bank_sel <= PWDATA[3:0]; // [R8]
      end
      if (hit_en) begin
        pat_en <= PWDATA[FLAG_LSB +: 3]; // [R9]
      end
      if (hit_imask) begin
        irq_mask <= PWDATA[FLAG_LSB +: 3];
      end
    end
  end

  // Receive side: byte position within the frame, reset after the last byte.
  assign rx.valid       = RX_VALID;
  assign rx.last        = RX_LAST;
  assign rx.data        = RX_DATA;
  assign in_mask_window = (pos < 7'(MASK_BYTES));

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pos <= 7'h00;
    end else if (CE & RX_VALID) begin
      if (RX_LAST) begin
        pos <= 7'h00; // [R3]
      end else if (in_mask_window) begin
        pos <= pos + 7'h01;
      end
    end
  end

  for (genvar p = 0; p < NPAT; p++) begin : g_pat
    wire logic [63:0] mask;
    wire logic        sel;
    wire logic [31:0] crc_exp;

    // Mask registers in ascending byte order, bit 0 of each is its lowest byte.
    assign mask    = {store[p][5], store[p][4], store[p][3], store[p][2]}; // [R1] [R2]
    assign sel     = in_mask_window & mask[pos[5:0]]; // [R2] [R3]
    assign crc_exp = {store[p][1], store[p][0]}; // [R4]

    wfm_matcher u_match (
      .clock   (CLOCK),
      .rst     (RST),
      .ce      (CE),
      .rx      (rx),
      .sel     (sel),
      .en      (pat_en[p]),
      .crc_exp (crc_exp),
      .hit     (hit[p])
    );
  end

  // A detection in the same cycle as its write-one-to-clear survives the clear.
  always_comb begin
    next_status = status;
    if (wr & hit_stat & PSTRB[0]) begin
      next_status = status & ~PWDATA[FLAG_LSB +: 3];
    end
    next_status = next_status | hit; // [R10]
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      status     <= FLAG_RESET;
      WAKE_EVENT <= FLAG_RESET;
      IRQ        <= 1'b0;
    end else if (CE) begin
      status     <= next_status;
      WAKE_EVENT <= hit; // [R10]
      IRQ        <= |(next_status & irq_mask);
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  logic        past_rst;
  logic        seen_wr;
  logic [15:0] seen_val;

  always_ff @(posedge CLOCK) begin
    past_rst <= RST;
  end

  a_reset_zero: assert property ( // [R7]
    past_rst |-> (store[1][0] == REG_RESET) && (store[2][5] == REG_RESET)
                 && (store[0][2] == REG_RESET))
    else $error("Pattern register not zero after reset.");

  a_mask_bank_write: assert property ( // [R1]
    wr && bank_sel == 4'h6 && idx == IDX_MASK1 && PSTRB[1:0] == 2'b11
    |=> store[1][3] == $past(wdata16))
    else $error("Mask write in bank 6 did not land in pattern 2.");

  a_crc_half_order: assert property ( // [R4]
    wr && bank_sel == 4'h7 && idx == IDX_CRC_HIGH && PSTRB[1:0] == 2'b11
    |=> g_pat[2].crc_exp[31:16] == $past(wdata16) && $stable(g_pat[2].crc_exp[15:0]))
    else $error("Upper CRC half of pattern 3 misplaced.");

  a_bank_map: assert property ( // [R6]
    PSEL && PENABLE && !PREADY && CE && !PWRITE && bank_sel == 4'h5 && idx == IDX_MASK3
    |=> PRDATA == {16'h0000, $past(store[0][5])})
    else $error("Bank 5 mask read returned the wrong pattern.");

  a_empty_bank: assert property ( // [R8]
    PSEL && PENABLE && !PREADY && CE && bank_sel[3] && in_win
    |=> PSLVERR && PRDATA == 32'h00000000)
    else $error("Reserved bank answered as a register.");

  a_bank_sel_live: assert property ( // [R8]
    PSEL && PENABLE && !PREADY && CE && !PWRITE && hit_bank
    |=> !PSLVERR && PRDATA[3:0] == $past(bank_sel))
    else $error("Bank select unreadable.");

  a_first_byte: assert property ( // [R3]
    RX_VALID && pos == 7'h00 |-> g_pat[1].sel == store[1][2][0])
    else $error("Frame byte one not tied to mask bit 0.");

  a_group_edge: assert property ( // [R2]
    RX_VALID && pos == 7'h1f |-> g_pat[0].sel == store[0][3][15])
    else $error("Byte 32 not tied to bit 15 of the second mask.");

  a_disabled_quiet: assert property ( // [R9]
    WAKE_EVENT != 3'h0 |-> ($past(pat_en) & WAKE_EVENT) == WAKE_EVENT)
    else $error("Wake event from a disabled pattern.");

  a_event_sticky: assert property ( // [R10]
    CE && hit != 3'h0 |=> (WAKE_EVENT == $past(hit)) && ((status & $past(hit)) == $past(hit)))
    else $error("Detection did not reach event and status.");

  a_irq_level: assert property (
    CE && (next_status & irq_mask) != 3'h0 |=> IRQ)
    else $error("Unmasked status did not raise the interrupt.");

  a_irq_quiet: assert property (
    CE && (next_status & irq_mask) == 3'h0 |=> !IRQ)
    else $error("Interrupt high with no unmasked status.");

  a_ready_pulse: assert property (
    CE && PREADY |=> !PREADY)
    else $error("Ready held for more than one cycle.");

  // A frozen bus never raises PREADY, so a master must not time out while the enable is low.
  a_ce_freeze: assert property (
    !CE |=> $stable(bank_sel) && $stable(status) && $stable(pos) && $stable(PREADY)
            && $stable(IRQ) && $stable(WAKE_EVENT))
    else $error("State moved while the clock enable was low.");

  a_w1c_clear: assert property ( // [R10]
    wr && hit_stat && PSTRB[0] && hit == 3'h0
    |=> status == ($past(status) & ~$past(PWDATA[FLAG_LSB +: 3])))
    else $error("Write of ones did not clear the status bits.");

  a_status_hold: assert property ( // [R10]
    CE && !(wr && hit_stat) && hit == 3'h0 |=> status == $past(status))
    else $error("Status changed with no event and no clear.");

  a_bank_write: assert property ( // [R8]
    wr && hit_bank && PSTRB[0] |=> bank_sel == $past(PWDATA[3:0]))
    else $error("Bank select write lost.");

  a_enable_write: assert property ( // [R9]
    wr && hit_en && PSTRB[0] |=> pat_en == $past(PWDATA[FLAG_LSB +: 3]))
    else $error("Enable write lost.");

  a_disabled_parks: assert property ( // [R9]
    CE && RX_VALID && !pat_en[1] |=> g_pat[1].u_match.crc == CRC_INIT)
    else $error("Disabled pattern kept a running CRC.");

  a_crc_low_write: assert property ( // [R4]
    wr && bank_sel == 4'h6 && idx == IDX_CRC_LOW && PSTRB[1:0] == 2'b11
    |=> g_pat[1].crc_exp[15:0] == $past(wdata16))
    else $error("Lower CRC half of pattern 2 misplaced.");

  a_reserved_write: assert property ( // [R8]
    wr && bank_sel[3] && in_win
    |=> $stable(g_pat[0].mask) && $stable(g_pat[1].mask) && $stable(g_pat[2].mask))
    else $error("Write to a reserved bank changed a mask.");

  a_frame_restart: assert property ( // [R3]
    CE && RX_VALID && RX_LAST |=> pos == 7'h00)
    else $error("Byte count not restarted after the last byte.");

  a_byte_step: assert property ( // [R1]
    CE && RX_VALID && !RX_LAST && in_mask_window |=> pos == $past(pos) + 7'h01)
    else $error("Byte count skipped a byte.");

  always_ff @(posedge CLOCK) begin
    seen_wr  <= wr & hit_store;
    seen_val <= wdata16;
  end

  c_store_write: cover property (seen_wr && seen_val != 16'h0000);
  c_wake_hit:    cover property (WAKE_EVENT != 3'h0);
  c_clear_race:  cover property (wr && hit_stat && hit != 3'h0);
  c_slave_error: cover property (PREADY && PSLVERR);
  c_ce_pause:    cover property (!CE && RX_VALID);
endmodule : wfm_top
